/* core/epp_defines.svh */
/*
 Constants for the external parallel port: register offsets, field positions,
 reset values and sizes. Assumes inclusion by bare name from core/.
*/
`ifndef EPP_DEFINES_SVH
`define EPP_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte offsets (32-bit aligned words)
// ----------------------------------------------------------------------------
`define EPP_OFF_CTRL      6'h00
`define EPP_OFF_STATUS    6'h04
`define EPP_OFF_IRQ_STAT  6'h08
`define EPP_OFF_IRQ_MASK  6'h0c
`define EPP_OFF_TXDATA    6'h10
`define EPP_OFF_RXDATA    6'h14
`define EPP_OFF_WMARK     6'h18
`define EPP_OFF_CMD       6'h1c

// ----------------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------------
`define EPP_CTRL_MASTER   0
`define EPP_CTRL_WIDE     1
`define EPP_CTRL_CLKMODE  2
`define EPP_CTRL_RESET    3'h0

// ----------------------------------------------------------------------------
// Interrupt bits (status and mask share the layout)
// ----------------------------------------------------------------------------
`define EPP_IRQ_RDREQ     0
`define EPP_IRQ_RXFULL    1
`define EPP_IRQ_DONE      2
`define EPP_IRQ_W         3

// ----------------------------------------------------------------------------
// Command register fields
// ----------------------------------------------------------------------------
`define EPP_CMD_GO        0
`define EPP_CMD_WRITE     1

// Master-mode clock divider half period in mclk cycles
`define EPP_CLK_HALF      4'h1
`define EPP_WMARK_RESET   5'h08

`endif

/* core/epp_pkg.sv */
/*
 Types shared by the external parallel port modules.
 Assumes epp_defines.svh is on the include path.
*/
package epp_pkg;

    // Master access sequencer, Gray coded along idle-setup-strobe-finish
    typedef enum logic [1:0] {
        EPP_IDLE   = 2'b00,
        EPP_SETUP  = 2'b01,
        EPP_STROBE = 2'b11,
        EPP_FINISH = 2'b10
    } epp_state_t;

endpackage : epp_pkg

/* core/epp_port.sv */
/*
 External parallel port: Wishbone register slave, transmit and receive
 queues and the pin logic of the parallel bus as master or slave.
 Assumes pins are synchronous to mclk and the pad ring resolves enables.
*/
// Summary of operation
// RULE1: data bus width programmable as eight or sixteen bits.
// RULE2: clock-or-select line is bidirectional: clock or chip select.
// RULE3: direction line input as slave, driven by the port as master.
// RULE4: direction line high means write, low means read.
// RULE5: master drives read strobe; as slave strobe held high.
// RULE6: read request high when transmit queue holds one access or more.
// RULE7: receive-full high when receive fill reaches the watermark.
// RULE8: wait low extends the access; master holds until wait releases.
// RULE9: read request falls when transmit queue holds less than one access.
`timescale 1ns/1ps
`include "epp_defines.svh"
module epp_port
    import epp_pkg::*;
#(
    parameter int AW = 4
) (
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [15:0] port_data_in,
    output logic      [15:0] port_data_out,
    output logic             port_data_oe,
    input  wire logic        port_clock_or_select_in,
    output logic             port_clock_or_select_out,
    output logic             port_clock_or_select_oe,
    input  wire logic        port_write_indicator_in,
    output logic             port_write_indicator_out,
    output logic             port_write_indicator_oe,
    output logic             port_read_strobe,
    output logic             port_read_request,
    output logic             port_receive_full,
    input  wire logic        port_wait_n,
    output logic             irq
);
    typedef struct packed {
        logic [31:0]         dat;
        logic                ack;
        logic [2:0]          ctrl;
        logic [4:0]          wmark;
        logic [`EPP_IRQ_W-1:0] ist;
        logic [`EPP_IRQ_W-1:0] imask;
        logic                irq;
        epp_state_t          st;
        logic                cmd_wr;
        logic [3:0]          div;
        logic [15:0]         dout;
        logic                doe;
        logic                cs_out;
        logic                cs_oe;
        logic                wr_out;
        logic                wr_oe;
        logic                rd_n;
        logic                rdreq;
        logic                rxfull;
        logic                cs_prev;
    } epp_s_t;

    epp_s_t s_reg;
    epp_s_t s_next;

    epp_queue_if #(.W(16), .AW(AW)) txq ();
    epp_queue_if #(.W(16), .AW(AW)) rxq ();

    epp_queue #(.W(16), .AW(AW)) u_txq (.mclk(mclk), .resetn(resetn), .q(txq));
    epp_queue #(.W(16), .AW(AW)) u_rxq (.mclk(mclk), .resetn(resetn), .q(rxq));

    // Width of one external access in queue entries is always one entry
    function automatic logic [15:0] epp_lane(input logic wide, input logic [15:0] d);
        epp_lane = wide ? d : {8'h00, d[7:0]};
    endfunction : epp_lane

    logic wb_req;
    logic wb_wr;
    logic master;
    logic wide;
    logic slave_sel;
    logic slave_edge;
    logic rx_hit;
    logic tx_hit;
    logic [4:0] fill5;
    assign wb_req     = wb_cyc_i && wb_stb_i && !s_reg.ack;
    // Writes land at the ack edge, while the master still holds the request
    assign wb_wr      = wb_cyc_i && wb_stb_i && s_reg.ack && wb_we_i && wb_sel_i[0];
    assign master     = s_reg.ctrl[`EPP_CTRL_MASTER];
    assign wide       = s_reg.ctrl[`EPP_CTRL_WIDE];
    // Slave access: select active (low), taken on the falling edge from idle to select
    assign slave_sel  = !port_clock_or_select_in;
    assign slave_edge = !master && slave_sel && s_reg.cs_prev && port_wait_n;
    assign fill5      = 5'(rxq.fill);

    // ------------------------------------------------------------------------
    // Next-state logic: bus slave, sequencer and pin drivers
    // ------------------------------------------------------------------------
    always_comb begin
        s_next     = s_reg;
        txq.push   = 1'b0;
        txq.wdata  = epp_lane(wide, wb_dat_i[15:0]);
        txq.pop    = 1'b0;
        rxq.push   = 1'b0;
        rxq.wdata  = epp_lane(wide, port_data_in);
        rxq.pop    = 1'b0;
        rx_hit     = 1'b0;
        tx_hit     = 1'b0;
        s_next.ack = wb_req;
        s_next.dat = 32'h0000_0000;
        s_next.cs_prev = !slave_sel;

        // Register reads
        if (wb_req && !wb_we_i) begin
            unique case (wb_adr_i)
                `EPP_OFF_CTRL:     s_next.dat = {29'h0, s_reg.ctrl};
                `EPP_OFF_STATUS:   s_next.dat = {16'h0, 3'h0, fill5,
                                                 3'h0, 5'(txq.fill)};
                `EPP_OFF_IRQ_STAT: s_next.dat = {29'h0, s_reg.ist};
                `EPP_OFF_IRQ_MASK: s_next.dat = {29'h0, s_reg.imask};
                `EPP_OFF_RXDATA: begin
                    s_next.dat = {16'h0, rxq.rdata};
                    rxq.pop    = !rxq.empty;
                end
                `EPP_OFF_WMARK:    s_next.dat = {27'h0, s_reg.wmark};
                default:           s_next.dat = 32'h0000_0000; // Unmapped reads zero
            endcase
        end

        // Register writes
        if (wb_wr) begin
            unique case (wb_adr_i)
                `EPP_OFF_CTRL:     s_next.ctrl  = wb_dat_i[2:0];  // [RULE1]
                `EPP_OFF_IRQ_MASK: s_next.imask = wb_dat_i[`EPP_IRQ_W-1:0];
                `EPP_OFF_WMARK:    s_next.wmark = wb_dat_i[4:0];
                `EPP_OFF_TXDATA:   txq.push     = !txq.full;
                default: ;
            endcase
        end

        // Master sequencer; wait low freezes the strobe phase
        unique case (s_reg.st)
            EPP_IDLE: begin
                s_next.doe   = 1'b0;
                s_next.rd_n  = 1'b1;
                s_next.cs_out = !s_reg.ctrl[`EPP_CTRL_CLKMODE];
                if (master && wb_wr && wb_adr_i == `EPP_OFF_CMD
                    && wb_dat_i[`EPP_CMD_GO]) begin
                    s_next.cmd_wr = wb_dat_i[`EPP_CMD_WRITE];
                    if (!wb_dat_i[`EPP_CMD_WRITE] || !txq.empty) begin
                        s_next.st  = EPP_SETUP;
                        s_next.div = `EPP_CLK_HALF;
                    end
                end
            end
            EPP_SETUP: begin
                s_next.wr_out = s_reg.cmd_wr;                    // [RULE4]
                s_next.cs_out = s_reg.ctrl[`EPP_CTRL_CLKMODE];   // [RULE2]
                if (s_reg.cmd_wr) begin
                    s_next.dout = txq.rdata;
                    s_next.doe  = 1'b1;
                end else begin
                    s_next.rd_n = 1'b0;                          // [RULE5]
                end
                s_next.st = EPP_STROBE;
            end
            EPP_STROBE: begin
                if (s_reg.div != 4'h0) begin
                    s_next.div = s_reg.div - 4'h1;
                end else if (port_wait_n) begin                  // [RULE8]
                    s_next.st = EPP_FINISH;
                    if (s_reg.cmd_wr) begin
                        txq.pop = 1'b1;
                        tx_hit  = 1'b1;
                    end else begin
                        rxq.push = !rxq.full;
                        rx_hit   = 1'b1;
                    end
                end
            end
            EPP_FINISH: begin
                s_next.rd_n   = 1'b1;
                s_next.doe    = 1'b0;
                s_next.cs_out = !s_reg.ctrl[`EPP_CTRL_CLKMODE];
                s_next.st     = EPP_IDLE;
            end
        endcase

        // Slave mode: take or give one entry per select pulse
        if (slave_edge) begin
            if (port_write_indicator_in) begin                   // [RULE3] [RULE4]
                rxq.push = !rxq.full;
                rx_hit   = 1'b1;
            end else begin
                txq.pop = !txq.empty;
            end
        end
        if (!master) begin
            s_next.st   = EPP_IDLE;
            s_next.rd_n = 1'b1;                                  // [RULE5]
            s_next.dout = txq.rdata;
            s_next.doe  = slave_sel && !port_write_indicator_in;
        end
        s_next.wr_oe = master;                                   // [RULE3]
        s_next.cs_oe = master;                                   // [RULE2]

        // Flags: one access is one queue entry at either width
        s_next.rdreq  = (txq.fill - {{AW{1'b0}}, txq.pop}) != '0;  // [RULE6] [RULE9]
        s_next.rxfull = (5'(rxq.fill) + {4'h0, rxq.push}
                         - {4'h0, rxq.pop}) >= s_reg.wmark;     // [RULE7]

        // Sticky events: set wins over write-one-to-clear
        if (wb_wr && wb_adr_i == `EPP_OFF_IRQ_STAT) begin
            s_next.ist = s_reg.ist & ~wb_dat_i[`EPP_IRQ_W-1:0];
        end
        if (s_next.rdreq && !s_reg.rdreq) begin
            s_next.ist[`EPP_IRQ_RDREQ] = 1'b1;
        end
        if (s_next.rxfull && !s_reg.rxfull) begin
            s_next.ist[`EPP_IRQ_RXFULL] = 1'b1;
        end
        if (rx_hit || tx_hit) begin
            s_next.ist[`EPP_IRQ_DONE] = 1'b1;
        end
        s_next.irq = |(s_next.ist & s_next.imask);
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_reg         <= '0;
            s_reg.ctrl    <= `EPP_CTRL_RESET;
            s_reg.wmark   <= `EPP_WMARK_RESET;
            s_reg.st      <= EPP_IDLE;
            s_reg.rd_n    <= 1'b1;
            s_reg.cs_out  <= 1'b1;
            s_reg.cs_prev <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // Every output straight from the state register
    assign wb_dat_o                 = s_reg.dat;
    assign wb_ack_o                 = s_reg.ack;
    assign port_data_out            = s_reg.dout;
    assign port_data_oe             = s_reg.doe;
    assign port_clock_or_select_out = s_reg.cs_out;
    assign port_clock_or_select_oe  = s_reg.cs_oe;
    assign port_write_indicator_out = s_reg.wr_out;
    assign port_write_indicator_oe  = s_reg.wr_oe;
    assign port_read_strobe         = s_reg.rd_n;
    assign port_read_request        = s_reg.rdreq;
    assign port_receive_full        = s_reg.rxfull;
    assign irq                      = s_reg.irq;
endmodule : epp_port

/* core/epp_queue.sv */
/*
 Synchronous byte/halfword queue with honest fill count.
 Assumes push is not given while full nor pop while empty.
*/
`timescale 1ns/1ps
module epp_queue #(
    parameter int W  = 16,
    parameter int AW = 4
) (
    input wire logic mclk,
    input wire logic resetn,
    epp_queue_if.queue q
);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } epp_qs_t;

    epp_qs_t       s_reg;
    epp_qs_t       s_next;
    logic [W-1:0]  mem [0:(1<<AW)-1];

    // ------------------------------------------------------------------------
    // Pointer update
    // ------------------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        if (q.push && !q.full) begin
            s_next.wp = s_reg.wp + 1'b1;
        end
        if (q.pop && !q.empty) begin
            s_next.rp = s_reg.rp + 1'b1;
        end
        s_next.cnt = s_reg.cnt + {{AW{1'b0}}, (q.push && !q.full)}
                   - {{AW{1'b0}}, (q.pop && !q.empty)};
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Storage has no reset; pointers guard stale words
    always_ff @(posedge mclk) begin
        if (q.push && !q.full) begin
            mem[s_reg.wp] <= q.wdata;
        end
    end

    assign q.rdata = mem[s_reg.rp];
    assign q.fill  = s_reg.cnt;
    assign q.full  = s_reg.cnt[AW];
    assign q.empty = (s_reg.cnt == '0);
endmodule : epp_queue

/* core/epp_queue_if.sv */
/*
 Carrier between the port top and its queue: push and pop sides with fill.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface epp_queue_if #(
    parameter int W = 16,
    parameter int AW = 4
);
    logic          push;
    logic [W-1:0]  wdata;
    logic          pop;
    logic [W-1:0]  rdata;
    logic [AW:0]   fill;
    logic          full;
    logic          empty;

    modport owner (output push, output wdata, output pop,
                   input rdata, input fill, input full, input empty);
    modport queue (input push, input wdata, input pop,
                   output rdata, output fill, output full, output empty);
endinterface : epp_queue_if

/* verif/epp_ext_model.sv */
/*
 Far-side device: answers master accesses with wait states, and acts as
 an external master pushing words in slave mode. Assumes the bench resolves pins.
*/
`timescale 1ns/1ps
module epp_ext_model (
    input  wire logic        mclk,
    input  wire logic        wi_line,
    input  wire logic        rs_n,
    input  wire logic        doe,
    input  wire logic [15:0] dout,
    output logic      [15:0] din,
    output logic             wait_n,
    output logic             cs_m,
    output logic             wi_m
);
    logic [15:0] rd_val, wr_seen, sl_d;
    int          dly, cnt;
    initial begin
        rd_val = 16'h1234; dly = 3; cnt = 0; cs_m = 1'b1; wi_m = 1'b0;
        wr_seen = 16'h0000; sl_d = 16'h0000;
    end
    // Wait held low for dly cycles of each master access
    always @(posedge mclk) cnt <= (!rs_n || doe) ? cnt + 1 : 0;
    assign wait_n = !(!rs_n || doe) || cnt >= dly;
    // Write data taken only once wait is released
    always @(posedge mclk) if (doe && wi_line && wait_n) wr_seen <= dout;
    // Undriven bus shows the inverse, never a stale copy
    assign din = !rs_n ? rd_val : (!cs_m ? sl_d : ~rd_val);
    // External master write: select low two cycles, direction high
    task slave_write(input logic [15:0] d);
        @(posedge mclk);
        cs_m <= 1'b0; wi_m <= 1'b1; sl_d <= d;
        repeat (2) @(posedge mclk);
        cs_m <= 1'b1;
        @(posedge mclk);
    endtask : slave_write
endmodule : epp_ext_model

/* verif/epp_port_sva.sv */
/*
 Checker for the parallel port pins and the register bus handshake.
 Assumes binding to epp_port, one clock, reset async active low.
*/
`timescale 1ns/1ps
module epp_port_sva (
    input wire logic        mclk,
    input wire logic        resetn,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [5:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic        wb_ack_o,
    input wire logic        port_data_oe,
    input wire logic        port_clock_or_select_oe,
    input wire logic        port_write_indicator_out,
    input wire logic        port_write_indicator_oe,
    input wire logic        port_read_strobe,
    input wire logic        port_read_request,
    input wire logic        port_wait_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    // Bus request and transmit push steps
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_push;
        s_req ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == 6'h10);
    endsequence

    AST_ACK_ONE: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single pulse after request");
    AST_RDREQ_PUSH: assert property (s_push |-> ##[1:3] port_read_request)
        else $error("read request missing after push");
    AST_SLAVE_STROBE: assert property (!port_write_indicator_oe |-> port_read_strobe)
        else $error("strobe low in slave mode");
    AST_READ_DIR: assert property (!port_read_strobe |-> port_write_indicator_oe && !port_write_indicator_out)
        else $error("read strobe without read direction");
    AST_WRITE_DIR: assert property (port_data_oe && port_write_indicator_oe |-> port_write_indicator_out)
        else $error("data driven as master without write direction");
    AST_MASTER_CS: assert property (port_clock_or_select_oe |-> port_write_indicator_oe)
        else $error("select driven while direction not driven");
    AST_WAIT_READ: assert property (!port_read_strobe && !port_wait_n |=> !port_read_strobe)
        else $error("read ended while wait low");
    AST_WAIT_WRITE: assert property (port_data_oe && port_write_indicator_oe && !port_wait_n |=> port_data_oe)
        else $error("write ended while wait low");
    AST_STROBE_MIN: assert property ($fell(port_read_strobe) |-> !port_read_strobe [*3])
        else $error("read strobe too short");
endmodule : epp_port_sva

/* verif/test_external_bus_master_port_pins.sv */
/*
 Bench for the parallel port: register bus, master write and read, slave
 receive and watermark. Assumes epp_port, its queue and the far-side model.
*/
`timescale 1ns/1ps
`define CHK(nm, e, a) begin tests_run++; if ((a) !== (e)) begin err_count++; \
    $display("[ERR] %s exp %h got %h", nm, e, a); end end
module test_external_bus_master_port_pins;
    logic mclk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq, cs_m, wi_m, wait_n;
    logic [5:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic [15:0] din, dout;
    logic doe, cs_out, cs_oe, wi_out, wi_oe, rs_n, rdreq, rxfull;
    int err_count = 0, tests_run = 0;
    // Pin resolution: design drives when enabled, else the far side
    wire cs_line = cs_oe ? cs_out : cs_m;
    wire wi_line = wi_oe ? wi_out : wi_m;

    epp_port #(.AW(4)) epp_port_i (.mclk(mclk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port_data_in(din),
        .port_data_out(dout), .port_data_oe(doe), .port_clock_or_select_in(cs_line),
        .port_clock_or_select_out(cs_out), .port_clock_or_select_oe(cs_oe),
        .port_write_indicator_in(wi_line), .port_write_indicator_out(wi_out),
        .port_write_indicator_oe(wi_oe), .port_read_strobe(rs_n), .port_read_request(rdreq),
        .port_receive_full(rxfull), .port_wait_n(wait_n), .irq(irq));
    epp_ext_model epp_ext_model_i (.mclk(mclk), .wi_line(wi_line), .rs_n(rs_n), .doe(doe),
        .dout(dout), .din(din), .wait_n(wait_n), .cs_m(cs_m), .wi_m(wi_m));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // Closing report, also reached from any timeout
    task results;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results

    // Classic single Wishbone cycle, bounded wait for ack
    task wb(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= w; wb_adr_i <= a; wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        n = 0;
        do begin @(posedge mclk); n++; end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
        if (wb_ack_o !== 1'b1) begin err_count++; results; end
    endtask : wb

    // Poll the done event, bounded
    task wait_done;
        for (int n = 0; n < 40; n++) begin
            wb(1'b0, 6'h08, 32'h0);
            if (q[2] === 1'b1) return;
        end
        err_count++;
        results;
    endtask : wait_done

    task t_reset;
        `CHK("strobe", 1'b1, rs_n)
        `CHK("rdreq", 1'b0, rdreq)
        wb(1'b0, 6'h18, 32'h0); `CHK("wmark", 32'h8, q)
        wb(1'b1, 6'h20, 32'hffff_ffff);
        wb(1'b0, 6'h20, 32'h0); `CHK("unmapped", 32'h0, q)
        wb(1'b0, 6'h00, 32'h0); `CHK("ctrl", 32'h0, q)
        $display("test reset done");
    endtask : t_reset

    task t_master_write;
        wb(1'b1, 6'h00, 32'h7);
        wb(1'b1, 6'h0c, 32'h5);
        wb(1'b1, 6'h10, 32'ha5c3);
        repeat (2) @(posedge mclk);
        `CHK("rdreq", 1'b1, rdreq)
        `CHK("irq", 1'b1, irq)
        wb(1'b1, 6'h08, 32'h1);
        repeat (2) @(posedge mclk);
        `CHK("irq clr", 1'b0, irq)
        wb(1'b1, 6'h1c, 32'h3);
        // Mid-strobe: clock mode drives the shared line high while active
        repeat (2) @(posedge mclk);
        `CHK("cs out", 1'b1, cs_out)
        `CHK("cs oe", 1'b1, cs_oe)
        `CHK("dir out", 1'b1, wi_out)
        `CHK("data oe", 1'b1, doe)
        wait_done;
        `CHK("wr data", 16'ha5c3, epp_ext_model_i.wr_seen)
        `CHK("rdreq", 1'b0, rdreq)
        `CHK("irq done", 1'b1, irq)
        wb(1'b1, 6'h08, 32'h7);
        $display("test master write done");
    endtask : t_master_write

    task t_master_read;
        epp_ext_model_i.dly = 5;
        wb(1'b1, 6'h0c, 32'h0);
        wb(1'b1, 6'h00, 32'h1);
        wb(1'b1, 6'h1c, 32'h1);
        // Mid-strobe: select mode drives the shared line low while active
        repeat (2) @(posedge mclk);
        `CHK("cs out", 1'b0, cs_out)
        `CHK("read strobe", 1'b0, rs_n)
        `CHK("dir out", 1'b0, wi_out)
        wait_done;
        `CHK("irq masked", 1'b0, irq)
        wb(1'b1, 6'h08, 32'h7);
        wb(1'b0, 6'h14, 32'h0); `CHK("rd byte", 32'h34, q)
        $display("test master read done");
    endtask : t_master_read

    task t_slave_rx;
        wb(1'b1, 6'h00, 32'h0);
        wb(1'b1, 6'h18, 32'h2);
        epp_ext_model_i.slave_write(16'h00aa);
        `CHK("rxfull", 1'b0, rxfull)
        epp_ext_model_i.slave_write(16'h0055);
        repeat (2) @(posedge mclk);
        `CHK("rxfull", 1'b1, rxfull)
        `CHK("dir oe", 1'b0, wi_oe)
        `CHK("strobe", 1'b1, rs_n)
        wb(1'b0, 6'h14, 32'h0); `CHK("rx0", 32'haa, q)
        wb(1'b0, 6'h14, 32'h0); `CHK("rx1", 32'h55, q)
        repeat (2) @(posedge mclk);
        `CHK("rxfull", 1'b0, rxfull)
        $display("test slave receive done");
    endtask : t_slave_rx

    initial begin
        resetn = 1'b0; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0;
        wb_adr_i = 6'h00; wb_dat_i = 32'h0;
        wb_sel_i = 4'h0;
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        t_reset;
        t_master_write;
        t_master_read;
        t_slave_rx;
        results;
    end
endmodule : test_external_bus_master_port_pins

bind epp_port epp_port_sva epp_port_sva_i (.mclk(mclk), .resetn(resetn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_ack_o(wb_ack_o), .port_data_oe(port_data_oe),
    .port_clock_or_select_oe(port_clock_or_select_oe),
    .port_write_indicator_out(port_write_indicator_out),
    .port_write_indicator_oe(port_write_indicator_oe), .port_read_strobe(port_read_strobe),
    .port_read_request(port_read_request), .port_wait_n(port_wait_n));
